// ---- rtl/icc_input_chain.sv ----
// input conditioning chain: compensation, burnout, averaging, lag, bias
`timescale 1ns/1ps
`default_nettype none
`include "icc_map.svh"

module icc_input_chain
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // ahb-lite register bus
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // variant strap pin
  input  wire logic               highSpeedPin,
  // front end samples
  input  wire logic               sampleValid,
  output logic                    sampleReady,
  input  wire logic signed [31:0] sampleValue,
  input  wire logic               sampleOpen,
  input  wire logic signed [31:0] junctionTemp,
  // downstream results
  output logic                    resultValid,
  output icc_result_t             result,
  // interrupt
  output logic                    irq
);

  // bus and configuration state
  icc_ctrl_t          ctrl, next_ctrl;
  logic [8:0]         avgCount, next_avgCount;
  logic [8:0]         lagCoef, next_lagCoef;
  logic signed [31:0] compTemp, next_compTemp;
  logic signed [31:0] bias, next_bias;
  logic signed [31:0] spanLo, next_spanLo;
  logic signed [31:0] spanHi, next_spanHi;
  logic signed [15:0] boPctLo, next_boPctLo;
  logic signed [15:0] boPctHi, next_boPctHi;
  logic [2:0]         intStat, next_intStat;
  logic [2:0]         intMask, next_intMask;
  logic               wrPend, next_wrPend;
  logic [7:0]         wrAddr, next_wrAddr;
  logic               wrWord, next_wrWord;
  logic [31:0]        rdData, next_rdData;
  logic               avgFlush, next_avgFlush;
  logic               hsMeta, next_hsMeta;
  logic               hsSync, next_hsSync;

  // processing state
  icc_state_t         pState, next_pState;
  logic signed [31:0] work, next_work;
  logic               openFlag, next_openFlag;
  logic               isBurn, next_isBurn;
  logic signed [40:0] sum, next_sum;
  logic [8:0]         wrIdx, next_wrIdx;
  logic [8:0]         fill, next_fill;
  logic signed [31:0] lagY, next_lagY;
  logic               lagInit, next_lagInit;
  logic [47:0]        divMag, next_divMag;
  logic [8:0]         divRem, next_divRem;
  logic [8:0]         divDen, next_divDen;
  logic [5:0]         divCnt, next_divCnt;
  logic               divNeg, next_divNeg;
  logic               divForLag, next_divForLag;
  icc_result_t        next_result;
  logic               next_resultValid;
  logic               evBurn, next_evBurn;

  // averaging history
  logic signed [31:0] avgMem [0:511];
  logic               memWe;
  logic [8:0]         memIdx;
  logic signed [31:0] memData;

  // shared combinational terms
  logic               avgOn, lagOn, isContact;
  logic signed [47:0] boLo, boHi;

  // features gated by range type and variant
  always_comb
  begin
    isContact = (ctrl.rangeType == RNG_CONTACT);
    avgOn     = ctrl.avgEn && !isContact;
    lagOn     = ctrl.lagEn && hsSync && !isContact;
  end

  // burnout band from span and percent limits (tenths of a percent)
  always_comb
  begin
    logic signed [47:0] span;
    span = 48'(spanHi) - 48'(spanLo);
    boLo = 48'(spanLo) + (span * 48'(boPctLo)) / $signed(`ICC_PCT_SCALE);
    boHi = 48'(spanLo) + (span * 48'(boPctHi)) / $signed(`ICC_PCT_SCALE);
  end

  // register read mux
  function automatic logic [31:0] readReg(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      `ICC_OFS_CTRL:      d = 32'(ctrl);
      `ICC_OFS_AVG_COUNT: d = 32'(avgCount);
      `ICC_OFS_LAG_COEF:  d = 32'(lagCoef);
      `ICC_OFS_COMP_TEMP: d = compTemp;
      `ICC_OFS_BIAS:      d = bias;
      `ICC_OFS_SPAN_LO:   d = spanLo;
      `ICC_OFS_SPAN_HI:   d = spanHi;
      `ICC_OFS_BO_LIMIT:  d = {boPctHi, boPctLo};
      `ICC_OFS_RESULT:    d = result.value;
      `ICC_OFS_STATUS:    d = {16'h0000, 3'(pState), fill, hsSync,
                               result.burnout, result.overPos,
                               result.overNeg};
      `ICC_OFS_INT_STAT:  d = 32'(intStat);
      `ICC_OFS_INT_MASK:  d = 32'(intMask);
      default:            d = 32'h0000_0000;
    endcase
    return d;
  endfunction : readReg

  // bus decode, register writes, interrupt status
  always_comb
  begin
    logic       addrPhase;
    logic       refuse;
    logic [8:0] avgMax;
    icc_ctrl_t  c;
    addrPhase     = hsel && hready && htrans[1];
    refuse        = 1'b0;
    avgMax        = hsSync ? `ICC_AVG_MAX_FAST : `ICC_AVG_MAX_STD;
    c             = ctrl;
    next_ctrl     = ctrl;
    next_avgCount = avgCount;
    next_lagCoef  = lagCoef;
    next_compTemp = compTemp;
    next_bias     = bias;
    next_spanLo   = spanLo;
    next_spanHi   = spanHi;
    next_boPctLo  = boPctLo;
    next_boPctHi  = boPctHi;
    next_intMask  = intMask;
    next_avgFlush = 1'b0;
    next_hsMeta   = highSpeedPin;
    next_hsSync   = hsMeta;
    next_wrPend   = addrPhase && hwrite;
    next_wrAddr   = addrPhase ? haddr[7:0] : wrAddr;
    next_wrWord   = addrPhase ? (hsize == 3'b010) : wrWord;
    next_rdData   = (addrPhase && !hwrite) ? readReg(haddr[7:0]) : rdData;
    next_intStat  = intStat;
    // data phase of a word write
    if (wrPend && wrWord)
    begin
      unique case (wrAddr)
        `ICC_OFS_CTRL:
        begin
          c.avgEn     = hwdata[`ICC_CTRL_AVG];
          c.lagEn     = hwdata[`ICC_CTRL_LAG];
          c.extComp   = hwdata[`ICC_CTRL_EXT];
          c.burnout   = icc_burnout_t'(hwdata[`ICC_CTRL_BO +: 2]);
          c.rangeType = icc_range_t'(hwdata[`ICC_CTRL_RNG +: 3]);
          if (c.rangeType == RNG_CONTACT)
          begin
            c.lagEn = 1'b0;
            c.avgEn = 1'b0;
          end
          if (c.rangeType != RNG_THERMO)
            c.extComp = 1'b0;
          if (c.burnout != BO_OFF && c.burnout != BO_UP
              && c.burnout != BO_DOWN)
            refuse = 1'b1;
          else
            next_ctrl = c;
          next_avgFlush = 1'b1;
        end
        `ICC_OFS_AVG_COUNT:
        begin
          if (hwdata[31:9] == 23'h00_0000 && hwdata[8:0] >= `ICC_AVG_MIN
              && hwdata[8:0] <= avgMax)
          begin
            next_avgCount = hwdata[8:0];
            next_avgFlush = 1'b1;
          end
          else
            refuse = 1'b1;
        end
        `ICC_OFS_LAG_COEF:
        begin
          if (hwdata[31:9] == 23'h00_0000 && hwdata[8:0] >= `ICC_LAG_MIN
              && hwdata[8:0] <= `ICC_LAG_MAX && !isContact)
            next_lagCoef = hwdata[8:0];
          else
            refuse = 1'b1;
        end
        `ICC_OFS_COMP_TEMP:
        begin
          if ($signed(hwdata) >= $signed(`ICC_COMP_MIN)
              && $signed(hwdata) <= $signed(`ICC_COMP_MAX)
              && ctrl.rangeType == RNG_THERMO)
            next_compTemp = hwdata;
          else
            refuse = 1'b1;
        end
        `ICC_OFS_BIAS:
        begin
          if ($signed(hwdata) >= $signed(`ICC_BIAS_MIN)
              && $signed(hwdata) <= $signed(`ICC_BIAS_MAX) && !isContact)
            next_bias = hwdata;
          else
            refuse = 1'b1;
        end
        `ICC_OFS_SPAN_LO:  next_spanLo = hwdata;
        `ICC_OFS_SPAN_HI:  next_spanHi = hwdata;
        `ICC_OFS_BO_LIMIT:
        begin
          next_boPctLo = hwdata[15:0];
          next_boPctHi = hwdata[31:16];
        end
        `ICC_OFS_INT_STAT: next_intStat = intStat & ~hwdata[2:0];
        `ICC_OFS_INT_MASK: next_intMask = hwdata[2:0];
        default:           refuse = 1'b0;
      endcase
    end
    // events set after the clear so a set wins
    next_intStat[`ICC_INT_DONE]   = next_intStat[`ICC_INT_DONE]
                                    | resultValid;
    next_intStat[`ICC_INT_BURN]   = next_intStat[`ICC_INT_BURN] | evBurn;
    next_intStat[`ICC_INT_REFUSE] = next_intStat[`ICC_INT_REFUSE] | refuse;
  end

  // bus and configuration registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl     <= '{rangeType: RNG_VOLT, burnout: BO_OFF, extComp: 1'b0,
                    lagEn: 1'b0, avgEn: 1'b0};
      avgCount <= `ICC_RST_AVG_COUNT;
      lagCoef  <= `ICC_RST_LAG_COEF;
      compTemp <= `ICC_RST_COMP_TEMP;
      bias     <= `ICC_RST_BIAS;
      spanLo   <= `ICC_RST_SPAN_LO;
      spanHi   <= `ICC_RST_SPAN_HI;
      boPctLo  <= `ICC_RST_BO_LO;
      boPctHi  <= `ICC_RST_BO_HI;
      intStat  <= 3'h0;
      intMask  <= 3'h0;
      wrPend   <= 1'b0;
      wrAddr   <= 8'h00;
      wrWord   <= 1'b0;
      rdData   <= 32'h0000_0000;
      avgFlush <= 1'b0;
      hsMeta   <= 1'b0;
      hsSync   <= 1'b0;
    end
    else
    begin
      ctrl     <= next_ctrl;
      avgCount <= next_avgCount;
      lagCoef  <= next_lagCoef;
      compTemp <= next_compTemp;
      bias     <= next_bias;
      spanLo   <= next_spanLo;
      spanHi   <= next_spanHi;
      boPctLo  <= next_boPctLo;
      boPctHi  <= next_boPctHi;
      intStat  <= next_intStat;
      intMask  <= next_intMask;
      wrPend   <= next_wrPend;
      wrAddr   <= next_wrAddr;
      wrWord   <= next_wrWord;
      rdData   <= next_rdData;
      avgFlush <= next_avgFlush;
      hsMeta   <= next_hsMeta;
      hsSync   <= next_hsSync;
    end
  end

  // bus answers and interrupt line
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = rdData;
  assign irq         = |(intStat & intMask);
  assign sampleReady = (pState == P_IDLE);

  // per-scan processing sequence
  always_comb
  begin
    logic               stdRange, boRange, detect;
    logic [9:0]         oldIdx;
    logic signed [31:0] oldest;
    logic signed [40:0] newSum;
    logic signed [47:0] dvd;
    logic signed [47:0] quo;
    logic signed [32:0] diff;
    logic [9:0]         trial;
    logic               ge;
    stdRange         = (ctrl.rangeType == RNG_STD_SIGNAL)
                       || (ctrl.rangeType == RNG_STD_LOOP);
    boRange          = stdRange || (ctrl.rangeType == RNG_THERMO)
                       || (ctrl.rangeType == RNG_RES_THERM);
    detect           = 1'b0;
    oldIdx           = 10'(wrIdx) + `ICC_AVG_DEPTH - 10'(avgCount);
    if (oldIdx >= `ICC_AVG_DEPTH)
      oldIdx = oldIdx - `ICC_AVG_DEPTH;
    oldest           = avgMem[oldIdx[8:0]];
    newSum           = sum;
    dvd              = 48'h0000_0000_0000;
    quo              = divNeg ? -$signed(divMag) : $signed(divMag);
    diff             = 33'(work) - 33'(lagY);
    trial            = {divRem, divMag[47]};
    ge               = (trial >= 10'(divDen));
    next_pState      = pState;
    next_work        = work;
    next_openFlag    = openFlag;
    next_isBurn      = isBurn;
    next_sum         = sum;
    next_wrIdx       = wrIdx;
    next_fill        = fill;
    next_lagY        = lagY;
    next_lagInit     = lagInit && lagOn;
    next_divMag      = divMag;
    next_divRem      = divRem;
    next_divDen      = divDen;
    next_divCnt      = divCnt;
    next_divNeg      = divNeg;
    next_divForLag   = divForLag;
    next_result      = result;
    next_resultValid = 1'b0;
    next_evBurn      = 1'b0;
    memWe            = 1'b0;
    memIdx           = wrIdx;
    memData          = work;
    unique case (pState)
      P_IDLE:
        if (sampleValid)
        begin
          next_work     = sampleValue;
          next_openFlag = sampleOpen;
          next_isBurn   = 1'b0;
          next_pState   = P_COMP;
        end
      P_COMP:
      begin
        // thermocouple only, internal or external source
        if (ctrl.rangeType == RNG_THERMO)
          next_work = work + (ctrl.extComp ? compTemp : junctionTemp);
        next_pState = P_CHECK;
      end
      P_CHECK:
      begin
        // standard ranges use band, others the open flag
        detect = stdRange ? (48'(work) < boLo || 48'(work) > boHi)
                          : openFlag;
        // unreliable at fast scans; no special handling
        // only listed ranges and when not off
        if (boRange && ctrl.burnout != BO_OFF && detect)
        begin
          next_isBurn = 1'b1;
          next_pState = P_OUT;
        end
        else if (avgOn)
        begin
          // running sum over the last Count samples
          newSum = sum + 41'(work)
                   - ((fill == avgCount) ? 41'(oldest) : 41'(0));
          next_sum    = newSum;
          memWe       = 1'b1;
          next_wrIdx  = (10'(wrIdx) == `ICC_AVG_DEPTH - 10'h001)
                        ? 9'h000 : wrIdx + 9'h001;
          next_fill   = (fill == avgCount) ? fill : fill + 9'h001;
          dvd         = 48'(newSum);
          next_divNeg = dvd[47];
          next_divMag = dvd[47] ? 48'(-dvd) : 48'(dvd);
          next_divDen = next_fill;
          next_divRem = 9'h000;
          next_divCnt = `ICC_DIV_STEPS;
          next_divForLag = 1'b0;
          next_pState = P_DIV;
        end
        else
          next_pState = lagOn ? P_LAG : P_BIAS;
      end
      P_DIV:
      begin
        // shift-subtract divider, one quotient bit per clock
        next_divRem = ge ? 9'(trial - 10'(divDen)) : trial[8:0];
        next_divMag = {divMag[46:0], ge};
        next_divCnt = divCnt - 6'h01;
        if (divCnt == 6'h00)
        begin
          next_divRem = divRem;
          next_divMag = divMag;
          if (divForLag)
          begin
            // move by one N-th of the difference
            next_lagY   = lagY + quo[31:0];
            next_work   = lagY + quo[31:0];
            next_pState = P_BIAS;
          end
          else
          begin
            next_work   = quo[31:0];
            next_pState = lagOn ? P_LAG : P_BIAS;
          end
        end
      end
      P_LAG:
      begin
        // one update per scan gives time constant scan times N
        if (!lagInit)
        begin
          next_lagY    = work;
          next_lagInit = 1'b1;
          next_pState  = P_BIAS;
        end
        else
        begin
          dvd            = 48'(diff);
          next_divNeg    = dvd[47];
          next_divMag    = dvd[47] ? 48'(-dvd) : 48'(dvd);
          next_divDen    = lagCoef;
          next_divRem    = 9'h000;
          next_divCnt    = `ICC_DIV_STEPS;
          next_divForLag = 1'b1;
          next_pState    = P_DIV;
        end
      end
      P_BIAS:
      begin
        // bias last, skipped on contact input
        if (!isContact)
          next_work = work + bias;
        next_pState = P_OUT;
      end
      P_OUT:
      begin
        next_resultValid      = 1'b1;
        next_evBurn           = isBurn;
        next_result.burnout   = isBurn;
        // up gives positive, down gives negative
        next_result.overPos   = isBurn && ctrl.burnout == BO_UP;
        next_result.overNeg   = isBurn && ctrl.burnout != BO_UP;
        next_result.value     = !isBurn ? work
                              : (ctrl.burnout == BO_UP) ? `ICC_OVER_POS
                                                       : `ICC_OVER_NEG;
        next_pState           = P_IDLE;
      end
      default: next_pState = P_IDLE;
    endcase
    // a changed count or mode restarts the history
    if (avgFlush)
    begin
      next_sum   = 41'(0);
      next_fill  = 9'h000;
      next_wrIdx = 9'h000;
      memWe      = 1'b0;
    end
  end

  // processing registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pState      <= P_IDLE;
      work        <= 32'h0000_0000;
      openFlag    <= 1'b0;
      isBurn      <= 1'b0;
      sum         <= 41'(0);
      wrIdx       <= 9'h000;
      fill        <= 9'h000;
      lagY        <= 32'h0000_0000;
      lagInit     <= 1'b0;
      divMag      <= 48'h0000_0000_0000;
      divRem      <= 9'h000;
      divDen      <= 9'h001;
      divCnt      <= 6'h00;
      divNeg      <= 1'b0;
      divForLag   <= 1'b0;
      result      <= '0;
      resultValid <= 1'b0;
      evBurn      <= 1'b0;
    end
    else
    begin
      pState      <= next_pState;
      work        <= next_work;
      openFlag    <= next_openFlag;
      isBurn      <= next_isBurn;
      sum         <= next_sum;
      wrIdx       <= next_wrIdx;
      fill        <= next_fill;
      lagY        <= next_lagY;
      lagInit     <= next_lagInit;
      divMag      <= next_divMag;
      divRem      <= next_divRem;
      divDen      <= next_divDen;
      divCnt      <= next_divCnt;
      divNeg      <= next_divNeg;
      divForLag   <= next_divForLag;
      result      <= next_result;
      resultValid <= next_resultValid;
      evBurn      <= next_evBurn;
    end
  end

  // averaging history write, no reset needed
  always_ff @(posedge clk)
  begin
    if (memWe)
      avgMem[memIdx] <= memData;
  end

endmodule : icc_input_chain
`default_nettype wire

// ---- rtl/icc_map.svh ----
// register offsets, field positions, reset values and limits of the chain
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH
// register byte offsets
`define ICC_OFS_CTRL      8'h00
`define ICC_OFS_AVG_COUNT 8'h04
`define ICC_OFS_LAG_COEF  8'h08
`define ICC_OFS_COMP_TEMP 8'h0C
`define ICC_OFS_BIAS      8'h10
`define ICC_OFS_SPAN_LO   8'h14
`define ICC_OFS_SPAN_HI   8'h18
`define ICC_OFS_BO_LIMIT  8'h1C
`define ICC_OFS_RESULT    8'h20
`define ICC_OFS_STATUS    8'h24
`define ICC_OFS_INT_STAT  8'h28
`define ICC_OFS_INT_MASK  8'h2C
// control field positions
`define ICC_CTRL_AVG      0
`define ICC_CTRL_LAG      1
`define ICC_CTRL_EXT      2
`define ICC_CTRL_BO       3
`define ICC_CTRL_RNG      5
// interrupt bit positions
`define ICC_INT_DONE      0
`define ICC_INT_BURN      1
`define ICC_INT_REFUSE    2
// reset values
`define ICC_RST_AVG_COUNT 9'h002
`define ICC_RST_LAG_COEF  9'h003
`define ICC_RST_COMP_TEMP 32'h0000_0000
`define ICC_RST_BIAS      32'h0000_0000
`define ICC_RST_SPAN_LO   32'h0000_0000
`define ICC_RST_SPAN_HI   32'h0000_03E8
`define ICC_RST_BO_LO     16'hFF9C
`define ICC_RST_BO_HI     16'h044C
// limits (temperatures in tenths of a degree)
`define ICC_AVG_MIN       9'h002
`define ICC_AVG_MAX_STD   9'h064
`define ICC_AVG_MAX_FAST  9'h1F4
`define ICC_AVG_DEPTH     10'h1F4
`define ICC_LAG_MIN       9'h003
`define ICC_LAG_MAX       9'h12C
`define ICC_COMP_MIN      32'hFFFF_FF38
`define ICC_COMP_MAX      32'h0000_0320
`define ICC_BIAS_MIN      32'hFF67_6981
`define ICC_BIAS_MAX      32'h000F_423F
`define ICC_OVER_POS      32'h7FFF_FFFF
`define ICC_OVER_NEG      32'h8000_0001
`define ICC_PCT_SCALE     48'h0000_0000_03E8
`define ICC_DIV_STEPS     6'h30
`endif

// ---- rtl/icc_pkg.sv ----
// types shared by the input conditioning chain
package icc_pkg;
  typedef enum logic [2:0] {
    RNG_VOLT       = 3'b000,
    RNG_STD_SIGNAL = 3'b001,
    RNG_STD_LOOP   = 3'b010,
    RNG_THERMO     = 3'b011,
    RNG_RES_THERM  = 3'b100,
    RNG_RES_4WIRE  = 3'b101,
    RNG_CONTACT    = 3'b110,
    RNG_CURRENT_IN = 3'b111
  } icc_range_t;

  typedef enum logic [1:0] {
    BO_OFF  = 2'b00,
    BO_UP   = 2'b01,
    BO_DOWN = 2'b10
  } icc_burnout_t;

  typedef enum logic [2:0] {
    P_IDLE  = 3'b000,
    P_COMP  = 3'b001,
    P_CHECK = 3'b010,
    P_DIV   = 3'b011,
    P_LAG   = 3'b100,
    P_BIAS  = 3'b101,
    P_OUT   = 3'b110
  } icc_state_t;

  typedef struct packed {
    icc_range_t   rangeType;
    icc_burnout_t burnout;
    logic         extComp;
    logic         lagEn;
    logic         avgEn;
  } icc_ctrl_t;

  typedef struct packed {
    logic signed [31:0] value;
    logic               burnout;
    logic               overPos;
    logic               overNeg;
  } icc_result_t;
endpackage : icc_pkg

// ---- test/icc_chain_monitor.sv ----
// checker on the chain's bus and stream ports
`timescale 1ns/1ps
`default_nettype none
module icc_chain_monitor
  import icc_pkg::*;
(
  // observed ports
  input wire logic        clk, reset_n, hreadyout, hresp,
  input wire logic        sampleValid, sampleReady, resultValid,
  input wire icc_result_t result
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // handshake steps of one scan
  sequence taken_s;
    sampleValid && sampleReady;
  endsequence
  sequence done_s;
    resultValid && sampleReady; // idle again in the pulse cycle
  endsequence
  // bus slave answers at once
  zero_wait_a:
    assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  busy_hold_a:
    assert property (taken_s |=> !sampleReady)
    else $error("sample taken while busy");
  answer_time_a:
    assert property (taken_s |-> ##[4:110] done_s)
    else $error("no result in time");
  pulse_once_a:
    assert property (resultValid |=> !resultValid)
    else $error("result pulse too long");
  result_hold_a:
    assert property ($changed(result) |-> $rose(resultValid))
    else $error("result moved without pulse");
  up_value_a:
    assert property (resultValid && result.overPos |->
      result.value == 32'h7FFF_FFFF && !result.overNeg)
    else $error("bad positive over-range");
  down_value_a:
    assert property (resultValid && result.overNeg |->
      result.value == 32'h8000_0001 && !result.overPos)
    else $error("bad negative over-range");
  one_side_a:
    assert property (resultValid && result.burnout |->
      result.overPos != result.overNeg)
    else $error("burnout without one over-range");
endmodule : icc_chain_monitor
bind icc_input_chain icc_chain_monitor u_mon (.*);
`default_nettype wire

// ---- test/icc_front_end.sv ----
// behavioural front end giving one raw reading per scan
`timescale 1ns/1ps
`default_nettype none
module icc_front_end (
  // sample handshake
  input  wire logic       clk, sampleReady,
  output var logic        sampleValid, sampleOpen,
  output var logic [31:0] sampleValue, junctionTemp
);
  // idle, junction at a room reading
  initial
  begin
    sampleValid = 1'b0;
    sampleOpen = 1'b0;
    sampleValue = 32'h0000_0000;
    junctionTemp = 32'h0000_00FA;
  end
  // offer a reading, hold it until taken
  task automatic send(input logic [31:0] v, input logic o);
    sampleValid <= 1'b1;
    sampleValue <= v;
    sampleOpen <= o;
    do @(posedge clk); while (!sampleReady);
    sampleValid <= 1'b0;
    sampleValue <= ~v; // no stale reading
    sampleOpen <= ~o;
  endtask : send
endmodule : icc_front_end
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the input conditioning chain
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(35'(g), 35'(e))
module testbench;
  import icc_pkg::*;
  // bus, strap and observed signals
  logic        clk, reset_n, hsel, hwrite, highSpeedPin;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rdq;
  wire logic   hreadyout, hresp, sampleValid, sampleReady, sampleOpen;
  wire logic   resultValid, irq;
  wire logic [31:0] hrdata, sampleValue, junctionTemp;
  wire icc_result_t result;
  int          errCount, totalChecks, cyc;
  icc_input_chain DUT (.hready(hreadyout), .*);
  icc_front_end fe (.*);
  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errCount++;
      closeOut();
    end
  end
  // compare and count
  task automatic chk(input logic [34:0] g, input logic [34:0] e);
    totalChecks++;
    if (g !== e)
    begin
      errCount++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic closeOut;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : closeOut
  // one single ahb-lite transfer
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hreadyout);
    rdq = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    `CHK(rdq, e);
  endtask : rd
  // one scan through the chain
  task automatic smp(input logic [31:0] v, input logic o,
                     input logic [34:0] e);
    int n;
    fe.send(v, o);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!resultValid && n < 300);
    `CHK(resultValid, 1);
    `CHK(result, e);
  endtask : smp
  // test sequence
  initial
  begin
    reset_n = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    highSpeedPin = 1'b1;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, 0);
    rd(8'h04, 2);
    rd(8'h08, 3);
    rd(8'h0C, 0);
    rd(8'h10, 0);
    rd(8'h40, 0);
    $display("test defaults done");
    wr(8'h10, 5);
    smp(100, 0, {32'd105, 3'h0});
    wr(8'h00, 1);
    smp(10, 0, {32'd15, 3'h0});
    smp(30, 0, {32'd25, 3'h0});
    smp(50, 0, {32'd45, 3'h0});
    $display("test averaging done");
    wr(8'h04, 1);
    rd(8'h04, 2);
    wr(8'h04, 500);
    rd(8'h04, 500);
    wr(8'h08, 301);
    rd(8'h08, 3);
    wr(8'h08, 300);
    rd(8'h08, 300);
    rd(8'h28, 5);
    wr(8'h2C, 4);
    @(posedge clk);
    `CHK(irq, 1);
    wr(8'h28, 4);
    @(posedge clk);
    `CHK(irq, 0);
    rd(8'h28, 1);
    $display("test limits done");
    wr(8'h08, 3);
    wr(8'h00, 2);
    smp(300, 0, {32'd305, 3'h0});
    smp(0, 0, {32'd205, 3'h0});
    wr(8'h00, 8'h68);
    smp(10, 1, {32'h7FFF_FFFF, 3'h6});
    wr(8'h00, 8'h70);
    smp(10, 1, {32'h8000_0001, 3'h5});
    wr(8'h00, 8'h28);
    smp(1200, 0, {32'h7FFF_FFFF, 3'h6});
    smp(500, 0, {32'd505, 3'h0});
    wr(8'h00, 8'h20);
    smp(2000, 0, {32'd2005, 3'h0});
    wr(8'h00, 8'hA8);
    smp(10, 1, {32'd15, 3'h0});
    wr(8'h00, 8'h24);
    rd(8'h00, 8'h20);
    wr(8'h00, 8'h60);
    smp(10, 0, {32'd265, 3'h0});
    wr(8'h0C, 32'h0000_0321);
    rd(8'h0C, 0);
    wr(8'h0C, 100);
    wr(8'h00, 8'h64);
    rd(8'h00, 8'h64);
    smp(10, 0, {32'd115, 3'h0});
    $display("test filters and burnout done");
    wr(8'h00, 8'hC2);
    rd(8'h00, 8'hC0);
    wr(8'h10, 7);
    rd(8'h10, 5);
    smp(40, 0, {32'd40, 3'h0});
    rd(8'h20, 40);
    $display("test contact done");
    closeOut();
  end
endmodule : testbench
`default_nettype wire
